/* logic/sar_pkg.sv */
// Constants and carrier types for the 12-bit successive approximation register
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none

package sar_pkg;

  localparam int          RESULT_W    = 12;            // Result width
  localparam logic [11:0] RESULT_RST  = 12'hfff;       // Register value after reset
  localparam logic [11:0] TRIAL_FIRST = 12'h800;       // Trial marker on first bit
  localparam logic [11:0] START_PAT   = 12'h7ff;       // MSB low, rest high

  // Pin-side inputs after synchronisation
  typedef struct packed {
    logic comp_in;    // Comparator result
    logic start_n;    // Start request, low active
    logic enable_n;   // Expansion enable, low active
  } sar_in_s;

endpackage : sar_pkg

`default_nettype wire

/* logic/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_sync
  import sar_pkg::*;
#(
  parameter int           W   = 3,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         i_clk,     // System clock
  input  wire logic         i_resetn,  // Async reset, low active
  input  wire logic [W-1:0] i_pin,     // Raw pin levels
  output logic      [W-1:0] o_level    // Filtered levels
);

  //----------------------------------------------------------------------------
  // Synchroniser chain per bit
  //----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // First stage is read by the second stage only
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          s1_q  <= RST[g];
          s2_q  <= RST[g];
          s3_q  <= RST[g];
          lvl_q <= RST[g];
        end
        else
        begin
          s1_q <= i_pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            lvl_q <= s3_q;  // Change counts once stages two and three agree
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate

endmodule : pin_sync

`default_nettype wire

/* logic/sar_register.sv */
// 12-bit successive approximation register core
`default_nettype none

module sar_register
  import sar_pkg::*;
(
  input  wire logic                i_clk,                  // System clock, 200 MHz
  input  wire logic                i_resetn,               // Async reset, low active
  input  wire logic                i_register_clock,       // Register clock pin
  input  wire logic                i_comp_in,              // Comparator serial input
  input  wire logic                i_start_n,              // Start, low active
  input  wire logic                i_enable_n,             // Expansion enable, low active
  output logic [RESULT_W-1:0]      o_result_bits,          // Parallel result bits
  output logic                     o_msb_out,              // MSB (forced high when disabled)
  output logic                     o_msb_out_n,            // Inverse of MSB, sign bit
  output logic                     o_lsb_out,              // Least significant bit
  output logic                     o_serial_out,           // Comparator delayed one clock
  output logic                     o_conversion_finished_n // Done, low active
);

  //----------------------------------------------------------------------------
  // Pin synchronisation
  //----------------------------------------------------------------------------
  // Register clock is a pin from the other party; it is sampled, not used as a clock
  logic [3:0] raw_pins;
  logic [3:0] pins;
  assign raw_pins = {i_register_clock, i_comp_in, i_start_n, i_enable_n};

  // Stages reset to idle: register clock and comparator low, start and enable high,
  // so no false step follows reset and the MSB stays forced until enable settles
  pin_sync #(
    .W   (4),
    .RST (4'h3)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (raw_pins),
    .o_level  (pins)
  );

  sar_in_s in_s;
  logic    rclk_lvl;
  assign rclk_lvl = pins[3];
  assign in_s     = '{comp_in: pins[2], start_n: pins[1], enable_n: pins[0]};

  //----------------------------------------------------------------------------
  // Register clock edge enable
  //----------------------------------------------------------------------------
  // One-cycle pulse on each filtered rising edge of the register clock
  logic rclk_prev_q;
  logic step;
  assign step = rclk_lvl & ~rclk_prev_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rclk_prev_q <= 1'b0;
    else
      rclk_prev_q <= rclk_lvl;
  end

  //----------------------------------------------------------------------------
  // Successive approximation next-state
  //----------------------------------------------------------------------------
  // trial_q marks the bit under trial; zero once the LSB is decided
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] result_d;
  logic [RESULT_W-1:0] trial_q;
  logic [RESULT_W-1:0] trial_d;
  logic [RESULT_W-1:0] trial_next;
  logic [RESULT_W-1:0] decided;
  logic                done_n_q;
  logic                done_n_d;
  logic                serial_q;
  logic                converting;
  logic                launch;

  assign launch     = ~in_s.start_n & ~in_s.enable_n;
  assign converting = |trial_q;
  assign trial_next = trial_q >> 1;
  // Trial bit takes comparator value, next lower goes low, others hold
  assign decided    = (result_q & ~trial_q & ~trial_next)
                    | (trial_q & {RESULT_W{in_s.comp_in}});

  // Start wins while enabled; a finished register waits for a new start
  always_comb
  begin
    result_d = result_q;
    trial_d  = trial_q;
    done_n_d = done_n_q;
    if (in_s.enable_n)
    begin
      // Conversion inhibited, state unchanged
      result_d = result_q;
    end
    else if (launch)
    begin
      result_d = START_PAT;
      trial_d  = TRIAL_FIRST;
      done_n_d = 1'b1;
    end
    else if (converting)
    begin
      result_d = decided;
      trial_d  = trial_next;
      done_n_d = (trial_q != 12'h001);
    end
  end

  //----------------------------------------------------------------------------
  // State registers, advanced by the register clock enable
  //----------------------------------------------------------------------------
  // Reset gives a defined state though the pin behaviour treats it as unknown
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      result_q <= RESULT_RST;
      trial_q  <= '0;
      done_n_q <= 1'b1;
      serial_q <= 1'b0;
    end
    else if (step)
    begin
      result_q <= result_d;
      trial_q  <= trial_d;
      done_n_q <= done_n_d;
      serial_q <= in_s.comp_in;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  // Synchronised enable forces MSB high combinationally, so cascaded stages see it four clocks after the enable pin
  logic msb_eff;
  assign msb_eff                 = result_q[RESULT_W-1] | in_s.enable_n;
  assign o_result_bits           = {msb_eff, result_q[RESULT_W-2:0]};
  assign o_msb_out               = msb_eff;
  assign o_msb_out_n             = ~msb_eff;
  assign o_lsb_out               = result_q[0];
  assign o_serial_out            = serial_q;
  assign o_conversion_finished_n = done_n_q;

endmodule : sar_register

`default_nettype wire

/* bench/comparator_model.sv */
// Comparator model facing the register's ladder outputs
`default_nettype none
module comparator_model
(
  input  wire logic        i_clk,    // Bench clock
  input  wire logic [11:0] i_target, // Analog input as a code
  input  wire logic [11:0] i_ladder, // Register bits on the ladder
  output var logic         o_comp    // High while input exceeds ladder
);
  timeunit 1ns;
  timeprecision 100ps;
  // Moves on falling edges only, long before the next register step
  initial o_comp = 1'b0;
  always @(negedge i_clk) o_comp <= i_target > i_ladder;
endmodule : comparator_model
`default_nettype wire

/* bench/sar_register_asserts.sv */
// Port checks for the SAR register
`default_nettype none
module sar_register_chk
  import sar_pkg::*;
(
  input wire logic        i_clk,                  // Clock
  input wire logic        i_resetn,               // Reset
  input wire logic        i_register_clock,       // Step clock
  input wire logic        i_start_n,              // Start
  input wire logic        i_enable_n,             // Enable
  input wire logic [11:0] o_result_bits,          // Result
  input wire logic        o_msb_out,              // MSB
  input wire logic        o_msb_out_n,            // Sign
  input wire logic        o_lsb_out,              // LSB
  input wire logic        o_serial_out,           // Serial
  input wire logic        o_conversion_finished_n // Done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Pin copies; enable waits eight cycles because the sync lag is about four
  AST_SIGN: assert property (o_msb_out_n == !o_msb_out)
    else $error("sign bit wrong");
  AST_MSB: assert property (o_msb_out == o_result_bits[11])
    else $error("msb pin wrong");
  AST_LSB: assert property (o_lsb_out == o_result_bits[0])
    else $error("lsb pin wrong");
  AST_EN_FORCE: assert property (i_enable_n [*8] |-> o_msb_out)
    else $error("msb not forced");
  AST_EN_HOLD: assert property (i_enable_n [*8] |=>
    $stable(o_result_bits[10:0]) && $stable(o_conversion_finished_n))
    else $error("state moved while disabled");
  AST_START: assert property ((!i_start_n && !i_enable_n) [*7] ##0
    $rose(i_register_clock) |-> ##[3:10] (o_result_bits == START_PAT && o_conversion_finished_n))
    else $error("start pattern missing");
  AST_QUIET: assert property (!i_register_clock [*8] |=>
    $stable(o_conversion_finished_n) && $stable(o_serial_out))
    else $error("output moved without a step");
  AST_DONE: assert property ($fell(o_conversion_finished_n) |->
    o_serial_out == o_lsb_out && !$past(o_lsb_out))
    else $error("done without lsb decision");
  cover property ($fell(o_conversion_finished_n));
  cover property (o_result_bits == START_PAT);
  cover property (i_enable_n [*8]);
endmodule : sar_register_chk
bind sar_register sar_register_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_register_clock(i_register_clock), .i_start_n(i_start_n), .i_enable_n(i_enable_n),
  .o_result_bits(o_result_bits), .o_msb_out(o_msb_out), .o_msb_out_n(o_msb_out_n),
  .o_lsb_out(o_lsb_out), .o_serial_out(o_serial_out),
  .o_conversion_finished_n(o_conversion_finished_n));
`default_nettype wire

/* bench/testbench.sv */
// Bench for the SAR register with a comparator model
`default_nettype none
module testbench import sar_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        rclk = 1'b0;
  logic        start_n = 1'b1;
  logic        enable_n = 1'b0; // Low unless a step tests expansion
  logic        comp;
  logic [11:0] target = 12'h000;
  logic [11:0] last = 12'hfff;
  logic [11:0] result;
  logic        msb;
  logic        msb_n;
  logic        serial;
  logic        done_n;
  int          n_errors = 0;
  int          checked = 0;
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  sar_register u_sar_register (.i_clk(clk), .i_resetn(resetn), .i_register_clock(rclk),
    .i_comp_in(comp), .i_start_n(start_n), .i_enable_n(enable_n), .o_result_bits(result),
    .o_msb_out(msb), .o_msb_out_n(msb_n), .o_lsb_out(), .o_serial_out(serial),
    .o_conversion_finished_n(done_n));
  comparator_model u_comparator_model (.i_clk(clk), .i_target(target), .i_ladder(result),
    .o_comp(comp));
  task automatic stop_test();
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] exp);
    checked++;
    if ({msb, msb_n, done_n, serial, result} !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time,
               {msb, msb_n, done_n, serial, result}, exp);
    end
  endtask : chk
  // Inputs lead the step edge by 14 cycles, well past the sync lag
  task automatic step(input logic s_n, input logic e_n);
    @(negedge clk);
    start_n = s_n;
    enable_n = e_n;
    repeat (14) @(negedge clk);
    rclk = 1'b1;
    repeat (12) @(negedge clk);
    rclk = 1'b0;
  endtask : step
  // One conversion; a disabled step is slipped in ahead of step number stall
  task automatic conv(input logic [11:0] t, input int stall);
    logic [11:0] e;
    logic        d;
    logic        s;
    target = t;
    for (int k = 1; k <= 14; k++)
    begin
      if (k == stall)
      begin
        step(1'b1, 1'b1);
        chk({2'b10, d, t > {1'b1, e[10:0]}, 1'b1, e[10:0]});
      end
      e = (k > 12) ? t : (t & ~((12'h1 << (13 - k)) - 12'h1)) | ((12'h1 << (12 - k)) - 12'h1);
      d = (k < 13);
      s = (k == 1) ? (t > last) : (k < 14) && t[13 - k];
      step(k > 1, 1'b0);
      chk({e[11], ~e[11], d, s, e});
    end
    last = t;
  endtask : conv
  // Truncated continuous run: start is low while done or bit 3 is low, which also
  // restarts a register left finished; bit 3 going low ends each 8-bit conversion
  task automatic trunc(input logic [11:0] t);
    target = t;
    for (int k = 1; k <= 10; k++)
    begin
      step(done_n & result[3], 1'b0);
      if (k == 1)
        chk({3'b011, t > last, START_PAT});
      if (k == 9)
        chk({t[11], ~t[11], 1'b1, t[4], t[11:4], 4'h7});
      if (k == 10)
        chk({3'b011, t[3], START_PAT});
    end
  endtask : trunc
  // Back-to-back conversions restart straight from the finished state
  initial
  begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    chk({4'b1010, RESULT_RST});
    conv(12'ha5c, 5);
    conv(12'hfff, 13);
    conv(12'h000, 0);
    trunc(12'h3c9);
    stop_test();
  end
  // Run is near 1470 cycles, so this limit only trips on a hang
  initial
  begin
    repeat (10000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
